// [timer_regs.vh]
// Register map, field codes and reset values for the five-channel PWM timer.
// Assumes a plain register port with byte-wide addresses and one system clock.
// Contract
// - Writing a grouped counter presets every counter of that sync group together.
// - A sync-clear channel clears with any grouped counter whose own clear fires.
// - All five channels, zero to four, can join the sync group.
// - Plain PWM drives pin A high on match A, low on match B.
// - Plain PWM is enabled per channel, each with its own pin and compares.
// - Clearing on A or B compare allows duty from zero to full.
// - Equal A and B compares leave pin A unchanged on match.
// - Clear on B with A above B keeps the output low.
// - Clear on A with B above A keeps the output high.
// - Plain PWM also works free-running or inside a sync group.
// - Reset-sync mode pairs channels 3 and 4 into three pairs sharing the clear.
// - Reset-sync mode claims the six pair pins; channel 3 counts up only.
// - In reset-sync mode each second pin is the inverse of its first.
// - Reset-sync: channel 4 counter runs free; its compares watch channel 3.
// - Reset-sync: channel 3 clears to zero on its A compare, setting the period.
// - Reset-sync pairs toggle on B3, A4, B4 matches and all on the clear; the code sets all three on the clear and drops each on its own match.
// - Complementary mode drives three non-overlapping complementary pairs.
// - Complementary mode claims the six pins; channels 3 and 4 count up/down.
// - Complementary: count down from A3 match, count up on channel 4 underflow.
// - Complementary transitions come from B3, A4 and B4 compare matches.
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// Per-channel block: channel number times stride plus offset
`define CH_STRIDE 8'h04
`define OFF_CTRL 8'h00
`define OFF_COUNT 8'h01
`define OFF_CMPA 8'h02
`define OFF_CMPB 8'h03

// Shared registers
`define ADDR_START 8'h14
`define ADDR_SYNC 8'h15
`define ADDR_PWM 8'h16
`define ADDR_PAIR 8'h17
`define ADDR_STATUS 8'h18

// Clear source field in channel_control_register
`define CLR_NONE 2'h0
`define CLR_CMPA 2'h1
`define CLR_CMPB 2'h2
`define CLR_SYNC 2'h3

// Pair mode register bits
`define PAIR_RSYNC 0
`define PAIR_COMP 1
`define PAIR_POL3 2
`define PAIR_POL4 3

// Reset values
`define RST_COUNT 16'h0000
`define RST_CMP 16'hFFFF
`define RST_PAIR 4'hC

`endif

// [pwm_timer.v]
// Five-channel 16-bit timer with sync, plain PWM and channel 3/4 pair modes.
// Assumes one system clock, synchronous reset and a single-master register port.
`timescale 1ns/1ps
`include "timer_regs.vh"

module pwm_timer #(
  parameter CW = 16
) (
  input wire clock, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire [7:0] addr, // Register address
  input wire [CW-1:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [CW-1:0] rdata, // Read data, one cycle after rd
  output reg [4:0] pin_a_output, // Pin A levels
  output reg [4:0] pin_a_oe, // Pin A output enables
  output reg [4:0] pin_b_io, // Pin B levels, channels 3 and 4 only
  output reg [4:0] pin_b_oe, // Pin B output enables
  output reg pair_two_inverse_pin, // Pair two second pin
  output reg pair_three_inverse_pin, // Pair three second pin
  output reg pair_inverse_oe // Enable for the two inverse pins
);

  // One-hot direction of the shared channel 3/4 up/down count
  localparam DIR_UP = 2'b01;
  localparam DIR_DOWN = 2'b10;

  reg [CW-1:0] channel_counter [0:4];
  reg [CW-1:0] compare_a_register [0:4];
  reg [CW-1:0] compare_b_register [0:4];
  reg [1:0] channel_control_register [0:4];
  reg [4:0] start;
  reg [4:0] sync;
  reg [4:0] pwm_en;
  reg [3:0] pair_mode;
  reg [4:0] pwm_lvl;
  reg [2:0] rs_lvl;
  reg [2:0] cp_pos;
  reg [2:0] cp_neg;
  reg [1:0] dir_state;

  reg [CW-1:0] next_counter [0:4];
  reg [4:0] next_pwm_lvl;
  reg [2:0] next_rs_lvl;
  reg [2:0] next_cp_pos;
  reg [2:0] next_cp_neg;
  reg [1:0] next_dir_state;
  reg [4:0] match_a;
  reg [4:0] match_b;
  reg [4:0] own_clear;
  reg [4:0] clear;
  reg [4:0] load;
  reg [4:0] count_hit;
  reg [2:0] m3;
  reg [2:0] m4;
  reg [CW-1:0] pair_cmp [0:2];
  reg sync_clear;
  reg preset_all;
  reg rs_clear;
  reg [4:0] next_pin_a;
  reg [4:0] next_pin_b;
  reg next_inv_two;
  reg next_inv_three;
  reg [CW-1:0] next_rdata;
  integer i;

  wire rsync_mode;
  wire comp_mode;
  wire pair_on;
  wire pol3;
  wire pol4;
  wire count_down;

  // Comp mode wins if software sets both mode bits
  assign comp_mode = pair_mode[`PAIR_COMP];
  assign rsync_mode = pair_mode[`PAIR_RSYNC] & ~comp_mode;
  assign pair_on = comp_mode | rsync_mode;
  assign pol3 = pair_mode[`PAIR_POL3];
  assign pol4 = pair_mode[`PAIR_POL4];
  assign count_down = (dir_state == DIR_DOWN);

  function reg_hit;
    input [7:0] a;
    input [2:0] ch;
    input [7:0] off;
    begin
      reg_hit = (a == ({5'h00, ch} * `CH_STRIDE) + off);
    end
  endfunction

  // Pin level from internal active state and polarity bit
  function drive;
    input act;
    input pol;
    begin
      drive = pol ? act : ~act;
    end
  endfunction

  // One count step; wraps at both ends like the hardware counter
  function [CW-1:0] step;
    input [CW-1:0] val;
    input down;
    begin
      step = down ? val - {{(CW-1){1'b0}}, 1'b1} : val + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  always @*
  begin
    for (i = 0; i < 5; i = i + 1)
    begin
      match_a[i] = start[i] & (channel_counter[i] == compare_a_register[i]);
      match_b[i] = start[i] & (channel_counter[i] == compare_b_register[i]);
      own_clear[i] = ((channel_control_register[i] == `CLR_CMPA) & match_a[i]) |
                     ((channel_control_register[i] == `CLR_CMPB) & match_b[i]);
      count_hit[i] = wr & reg_hit(addr, i[2:0], `OFF_COUNT);
    end
    // Pair modes own the channel 3/4 compares; plain matches there would
    // disturb the plain level and the clear logic of those channels
    if (pair_on)
    begin
      match_a[3] = 1'b0;
      match_b[3] = 1'b0;
      match_a[4] = 1'b0;
      match_b[4] = 1'b0;
      own_clear[3] = 1'b0;
      own_clear[4] = 1'b0;
    end
    sync_clear = |(own_clear & sync);
    preset_all = |(count_hit & sync);
    for (i = 0; i < 5; i = i + 1)
    begin
      clear[i] = own_clear[i] |
                 ((channel_control_register[i] == `CLR_SYNC) & sync[i] & sync_clear);
      load[i] = count_hit[i] | (preset_all & sync[i]);
    end

    pair_cmp[0] = compare_b_register[3];
    pair_cmp[1] = compare_a_register[4];
    pair_cmp[2] = compare_b_register[4];
    for (i = 0; i < 3; i = i + 1)
    begin
      m3[i] = start[3] & (channel_counter[3] == pair_cmp[i]);
      m4[i] = start[4] & (channel_counter[4] == pair_cmp[i]);
    end
    // Period match of channel 3; both pair modes turn on it
    rs_clear = start[3] & (channel_counter[3] == compare_a_register[3]);

    // Counters
    for (i = 0; i < 5; i = i + 1)
    begin
      if (!start[i])
        next_counter[i] = channel_counter[i];
      else if (clear[i])
        next_counter[i] = `RST_COUNT;
      else
        next_counter[i] = step(channel_counter[i], 1'b0);
    end
    next_dir_state = dir_state;
    if (rsync_mode)
    begin
      if (start[3])
        next_counter[3] = rs_clear ? `RST_COUNT : step(channel_counter[3], 1'b0);
    end
    else if (comp_mode)
    begin
      // Both counters share one direction so the margin between them holds
      case (dir_state)
        DIR_UP:
        begin
          if (start[3] && rs_clear)
            next_dir_state = DIR_DOWN;
        end
        DIR_DOWN:
        begin
          if (start[4] && channel_counter[4] == `RST_COUNT)
            next_dir_state = DIR_UP;
        end
        default:
          next_dir_state = DIR_UP;
      endcase
      for (i = 3; i < 5; i = i + 1)
      begin
        if (start[i])
          next_counter[i] = step(channel_counter[i], next_dir_state == DIR_DOWN);
      end
    end
    else
      next_dir_state = DIR_UP;
    // A counter write beats the count step in the same cycle
    for (i = 0; i < 5; i = i + 1)
    begin
      if (load[i])
        next_counter[i] = wdata;
    end

    // Plain PWM levels
    next_pwm_lvl = pwm_lvl;
    for (i = 0; i < 5; i = i + 1)
    begin
      if (pwm_en[i] && !(match_a[i] && match_b[i]))
      begin
        if (match_a[i])
          next_pwm_lvl[i] = 1'b1;
        else if (match_b[i])
          next_pwm_lvl[i] = 1'b0;
      end
    end

    // Reset-sync pairs: clear sets all, each match drops its own
    next_rs_lvl = rs_lvl;
    if (rsync_mode)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        if (rs_clear)
          next_rs_lvl[i] = 1'b1;
        else if (m3[i])
          next_rs_lvl[i] = 1'b0;
      end
    end

    // Complementary pairs: the leading counter drops one side (negative counting up,
    // positive counting down) before the trailing counter raises the other, giving the dead time
    next_cp_pos = cp_pos;
    next_cp_neg = cp_neg;
    if (comp_mode)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        if (!count_down)
        begin
          if (m3[i])
            next_cp_neg[i] = 1'b0;
          if (m4[i])
            next_cp_pos[i] = 1'b1;
        end
        else
        begin
          if (m4[i])
            next_cp_pos[i] = 1'b0;
          if (m3[i])
            next_cp_neg[i] = 1'b1;
        end
      end
      // Interlock: the positive side stays off while its partner is on, so a
      // margin at or above the lowest transition value cannot overlap the pair
      for (i = 0; i < 3; i = i + 1)
      begin
        if (next_cp_neg[i])
          next_cp_pos[i] = 1'b0;
      end
    end
    else
    begin
      next_cp_pos = 3'h0;
      next_cp_neg = 3'h7;
    end

    // Pin mapping
    next_pin_a = next_pwm_lvl;
    next_pin_b = 5'h00;
    next_inv_two = 1'b0;
    next_inv_three = 1'b0;
    if (rsync_mode)
    begin
      next_pin_a[3] = drive(next_rs_lvl[0], pol3);
      next_pin_b[3] = ~drive(next_rs_lvl[0], pol3);
      next_pin_a[4] = drive(next_rs_lvl[1], pol4);
      next_inv_two = ~drive(next_rs_lvl[1], pol4);
      next_pin_b[4] = drive(next_rs_lvl[2], pol4);
      next_inv_three = ~drive(next_rs_lvl[2], pol4);
    end
    else if (comp_mode)
    begin
      next_pin_a[3] = drive(next_cp_pos[0], pol3);
      next_pin_b[3] = drive(next_cp_neg[0], pol3);
      next_pin_a[4] = drive(next_cp_pos[1], pol4);
      next_inv_two = drive(next_cp_neg[1], pol4);
      next_pin_b[4] = drive(next_cp_pos[2], pol4);
      next_inv_three = drive(next_cp_neg[2], pol4);
    end

    // Read mux, unmapped reads as zero
    next_rdata = {CW{1'b0}};
    for (i = 0; i < 5; i = i + 1)
    begin
      if (reg_hit(addr, i[2:0], `OFF_CTRL))
        next_rdata = {{(CW-2){1'b0}}, channel_control_register[i]};
      if (reg_hit(addr, i[2:0], `OFF_COUNT))
        next_rdata = channel_counter[i];
      if (reg_hit(addr, i[2:0], `OFF_CMPA))
        next_rdata = compare_a_register[i];
      if (reg_hit(addr, i[2:0], `OFF_CMPB))
        next_rdata = compare_b_register[i];
    end
    case (addr)
      `ADDR_START: next_rdata = {{(CW-5){1'b0}}, start};
      `ADDR_SYNC: next_rdata = {{(CW-5){1'b0}}, sync};
      `ADDR_PWM: next_rdata = {{(CW-5){1'b0}}, pwm_en};
      `ADDR_PAIR: next_rdata = {{(CW-4){1'b0}}, pair_mode};
      `ADDR_STATUS: next_rdata = {{(CW-13){1'b0}}, count_down, pin_b_io[4:3], pin_a_output, pwm_lvl};
      default: next_rdata = next_rdata;
    endcase
    if (!rd)
      next_rdata = {CW{1'b0}};
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        channel_counter[i] <= `RST_COUNT;
        compare_a_register[i] <= `RST_CMP;
        compare_b_register[i] <= `RST_CMP;
        channel_control_register[i] <= `CLR_NONE;
      end
      start <= 5'h00;
      sync <= 5'h00;
      pwm_en <= 5'h00;
      pair_mode <= `RST_PAIR;
      pwm_lvl <= 5'h00;
      rs_lvl <= 3'h0;
      cp_pos <= 3'h0;
      cp_neg <= 3'h7;
      dir_state <= DIR_UP;
      rdata <= {CW{1'b0}};
      pin_a_output <= 5'h00;
      pin_a_oe <= 5'h00;
      pin_b_io <= 5'h00;
      pin_b_oe <= 5'h00;
      pair_two_inverse_pin <= 1'b0;
      pair_three_inverse_pin <= 1'b0;
      pair_inverse_oe <= 1'b0;
    end
    else
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        channel_counter[i] <= next_counter[i];
        if (wr && reg_hit(addr, i[2:0], `OFF_CTRL))
          channel_control_register[i] <= wdata[1:0];
        if (wr && reg_hit(addr, i[2:0], `OFF_CMPA))
          compare_a_register[i] <= wdata;
        if (wr && reg_hit(addr, i[2:0], `OFF_CMPB))
          compare_b_register[i] <= wdata;
      end
      if (wr && addr == `ADDR_START)
        start <= wdata[4:0];
      if (wr && addr == `ADDR_SYNC)
        sync <= wdata[4:0];
      if (wr && addr == `ADDR_PWM)
        pwm_en <= wdata[4:0];
      if (wr && addr == `ADDR_PAIR)
        pair_mode <= wdata[3:0];
      pwm_lvl <= next_pwm_lvl;
      rs_lvl <= next_rs_lvl;
      cp_pos <= next_cp_pos;
      cp_neg <= next_cp_neg;
      dir_state <= next_dir_state;
      rdata <= next_rdata;
      pin_a_output <= next_pin_a;
      pin_a_oe <= pwm_en | {pair_on, pair_on, 3'h0};
      pin_b_io <= next_pin_b;
      pin_b_oe <= {pair_on, pair_on, 3'h0};
      pair_two_inverse_pin <= next_inv_two;
      pair_three_inverse_pin <= next_inv_three;
      pair_inverse_oe <= pair_on;
    end
  end

endmodule // pwm_timer

// [pwm_timer_properties.sv]
// Port checks for the five-channel PWM timer.
// Assumes pair and plain-PWM registers change only through the register port.
`timescale 1ns/1ps
`include "timer_regs.vh"
module pwm_timer_checker #(
  parameter CW = 16
) (
  input wire clock, // System clock
  input wire sys_rst, // Synchronous reset
  input wire [7:0] addr, // Register address
  input wire [CW-1:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  input wire [CW-1:0] rdata, // Read data
  input wire [4:0] pin_a_output, // Pin A levels
  input wire [4:0] pin_a_oe, // Pin A enables
  input wire [4:0] pin_b_io, // Pin B levels
  input wire [4:0] pin_b_oe, // Pin B enables
  input wire pair_two_inverse_pin, // Pair two second pin
  input wire pair_three_inverse_pin, // Pair three second pin
  input wire pair_inverse_oe // Inverse pin enable
);
  reg [3:0] pair_q;
  reg [4:0] pwm_q;
  wire rs = pair_q[0] & ~pair_q[1];
  wire cm = pair_q[1];
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      pair_q <= `RST_PAIR;
      pwm_q <= 5'h00;
    end
    else if (wr)
    begin
      if (addr == `ADDR_PAIR) pair_q <= wdata[3:0];
      if (addr == `ADDR_PWM) pwm_q <= wdata[4:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data not zero");
  rdata_unmap_a: assert property (rd && addr > `ADDR_STATUS |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  plain_oe_a: assert property ($stable(pwm_q) |-> pin_a_oe[2:0] == pwm_q[2:0])
    else $error("pin A enable wrong");
  pin_b_low_a: assert property (pin_b_io[2:0] == 3'h0 && pin_b_oe[2:0] == 3'h0)
    else $error("pin B driven on low channel");
  pair_oe_a: assert property ((rs || cm) [*2] |-> pin_b_oe[4:3] == 2'h3 && pin_a_oe[4:3] == 2'h3 && pair_inverse_oe)
    else $error("pair pins not enabled");
  pair_off_a: assert property ((!rs && !cm) [*2] |-> !pair_inverse_oe && pin_b_oe[4:3] == 2'h0)
    else $error("pair pins enabled outside pair modes");
  pair1_inv_a: assert property (rs [*2] |-> pin_b_io[3] == !pin_a_output[3])
    else $error("pair one not inverse");
  pair2_inv_a: assert property (rs [*2] |-> pair_two_inverse_pin == !pin_a_output[4])
    else $error("pair two not inverse");
  pair3_inv_a: assert property (rs [*2] |-> pair_three_inverse_pin == !pin_b_io[4])
    else $error("pair three not inverse");
  comp_gap1_a: assert property (cm [*2] |-> !(pin_a_output[3] == pair_q[2] && pin_b_io[3] == pair_q[2]))
    else $error("pair one overlap");
  comp_gap2_a: assert property (cm [*2] |-> !(pin_a_output[4] == pair_q[3] && pair_two_inverse_pin == pair_q[3]))
    else $error("pair two overlap");
  comp_gap3_a: assert property (cm [*2] |-> !(pin_b_io[4] == pair_q[3] && pair_three_inverse_pin == pair_q[3]))
    else $error("pair three overlap");
  cover property (rs ##1 pin_a_output[3]);
  cover property (cm ##1 pin_b_io[3]);
  cover property (rd ##1 rdata != 16'h0000);
endmodule // pwm_timer_checker

bind pwm_timer pwm_timer_checker #(.CW(CW)) u_pwm_timer_checker (.clock(clock), .sys_rst(sys_rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_a_output(pin_a_output), .pin_a_oe(pin_a_oe),
  .pin_b_io(pin_b_io), .pin_b_oe(pin_b_oe), .pair_two_inverse_pin(pair_two_inverse_pin),
  .pair_three_inverse_pin(pair_three_inverse_pin), .pair_inverse_oe(pair_inverse_oe));

// [pwm_load.sv]
// Power stage model: resolves nine timer pins and times one of them.
// Assumes pins are sampled on the system clock.
`timescale 1ns/1ps
module pwm_load (
  input wire clock, // System clock
  input wire clr, // Restart the high-time count
  input wire [3:0] sel, // Line to time
  input wire [8:0] drv, // Levels from the timer
  input wire [8:0] oe, // Enables from the timer
  output logic [15:0] hi_cnt // Cycles the line was high
);
  // Stage inputs have pull-downs, so a released pin reads low
  wire [8:0] line = drv & oe;
  always @(posedge clock)
    if (clr) hi_cnt <= 16'h0000;
    else hi_cnt <= hi_cnt + 16'(line[sel]);
endmodule // pwm_load

// [tb_top.sv]
// Self-checking bench for the PWM timer with a power stage model.
// Assumes the register map of timer_regs.vh.
`timescale 1ns/1ps
`include "timer_regs.vh"
module tb_top;
  reg clock, sys_rst, wr, rd, clr;
  reg [7:0] addr;
  reg [15:0] wdata;
  reg [3:0] sel;
  logic [15:0] v;
  wire [15:0] rdata, hi_cnt;
  wire [4:0] pa, pao, pb, pbo;
  wire inv2, inv3, inv_oe;
  int error_cnt, checks, cyc, a0, b0, p, last, up, dn;
  int ca[5], cb[5], ct[5], eh[9];
  pwm_timer #(.CW(16)) u_pwm_timer (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_a_output(pa), .pin_a_oe(pao), .pin_b_io(pb), .pin_b_oe(pbo),
    .pair_two_inverse_pin(inv2), .pair_three_inverse_pin(inv3), .pair_inverse_oe(inv_oe));
  pwm_load u_pwm_load (.clock(clock), .clr(clr), .sel(sel), .drv({inv3, inv2, pb[4:3], pa}),
    .oe({inv_oe, inv_oe, pbo[4:3], pao}), .hi_cnt(hi_cnt));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  task chk(input string n, input [15:0] e, input [15:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr_reg(input [7:0] a, input [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rd_reg(input [7:0] a, output [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Windows are whole periods, so the count does not depend on phase
  task meas(input [3:0] s, input int n, input int e);
    @(posedge clock);
    sel <= s;
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (n) @(posedge clock);
    #1 chk("pin high time", 16'(e), hi_cnt);
  endtask
  initial
  begin
    {sys_rst, wr, rd, clr} = 4'h9;
    addr = 8'h00;
    wdata = 16'h0000;
    sel = 4'h0;
    void'($urandom(56511));
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(`OFF_CMPA, v);
    chk("cmpa reset", `RST_CMP, v);
    rd_reg(`ADDR_PAIR, v);
    chk("pair reset", 16'(`RST_PAIR), v);
    rd_reg(8'h30, v);
    chk("unmapped read", 16'h0000, v);
    b0 = 5 + $urandom % 5;
    a0 = $urandom % b0;
    ca = '{a0, 3, 6, 4, 1};
    cb = '{b0, 8, 3, 4, 4};
    ct = '{2, 1, 2, 2, 3};
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(8'(i * 4) + `OFF_CTRL, 16'(ct[i]));
      wr_reg(8'(i * 4) + `OFF_CMPA, 16'(ca[i]));
      wr_reg(8'(i * 4) + `OFF_CMPB, 16'(cb[i]));
    end
    wr_reg(`ADDR_SYNC, 16'h0011);
    wr_reg(`OFF_COUNT, 16'h0003);
    rd_reg(8'h10 + `OFF_COUNT, v);
    chk("synced count", 16'h0003, v);
    rd_reg(8'h04 + `OFF_COUNT, v);
    chk("free count", 16'h0000, v);
    wr_reg(`ADDR_PWM, 16'h001F);
    wr_reg(`ADDR_START, 16'h001F);
    p = (b0 + 1) * 10;
    eh = '{(b0 - a0) * 10, p, 0, 0, 30, 0, 0, 0, 0};
    repeat (p) @(posedge clock);
    for (int i = 0; i < 5; i++) meas(4'(i), p, eh[i]);
    wr_reg(`ADDR_START, 16'h0000);
    wr_reg(`ADDR_SYNC, 16'h0000);
    wr_reg(8'h0C + `OFF_CTRL, 16'h0000);
    wr_reg(8'h10 + `OFF_CTRL, 16'h0000);
    wr_reg(8'h0C + `OFF_COUNT, 16'h0000);
    wr_reg(8'h0C + `OFF_CMPA, 16'h0009);
    wr_reg(8'h0C + `OFF_CMPB, 16'h0002);
    wr_reg(8'h10 + `OFF_CMPA, 16'h0005);
    wr_reg(8'h10 + `OFF_CMPB, 16'h0007);
    wr_reg(`ADDR_START, 16'h0008);
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(`ADDR_PAIR, k ? 16'h0009 : 16'h000D);
      eh = '{0, 0, 0, k ? 70 : 30, 60, k ? 30 : 70, 80, 40, 20};
      repeat (20) @(posedge clock);
      for (int i = 3; i < 9; i++) meas(4'(i), 100, eh[i]);
    end
    wr_reg(`ADDR_START, 16'h0000);
    wr_reg(`ADDR_PAIR, 16'h000C);
    wr_reg(8'h0C + `OFF_COUNT, 16'h0002);
    wr_reg(8'h10 + `OFF_COUNT, 16'h0000);
    wr_reg(8'h0C + `OFF_CMPA, 16'h0014);
    wr_reg(8'h0C + `OFF_CMPB, 16'h0008);
    wr_reg(8'h10 + `OFF_CMPA, 16'h000A);
    wr_reg(8'h10 + `OFF_CMPB, 16'h001E);
    wr_reg(`ADDR_PAIR, 16'h000E);
    wr_reg(`ADDR_START, 16'h0018);
    last = 2;
    repeat (40)
    begin
      rd_reg(8'h0C + `OFF_COUNT, v);
      if (v > last) up = 1;
      if (v < last) dn = 1;
      last = v;
    end
    chk("count up seen", 16'h0001, 16'(up));
    chk("count down seen", 16'h0001, 16'(dn));
    // Margin 2, period 36: pair one 20/12, pair two 16/16, pair three never matches
    eh = '{0, 0, 0, 200, 160, 120, 0, 160, 360};
    for (int i = 3; i < 9; i++) meas(4'(i), 360, eh[i]);
    end_of_test;
  end
endmodule // tb_top
